//--- atcfc_pkg.sv
/*
  Package for the acquisition trigger, clock and sample buffer control block.
  Holds register offsets, field positions, reset values, mode codes and timing counts.
  Assumes a 50 MHz system clock.
*/
package atcfc_pkg;

  localparam logic [5:0] OFF_DIVISOR   = 6'h04;
  localparam logic [5:0] OFF_TRIG_MODE = 6'h08;
  localparam logic [5:0] OFF_TRIG_LVL  = 6'h0c;
  localparam logic [5:0] OFF_TRIG_SRC  = 6'h10;
  localparam logic [5:0] OFF_POST_CNT  = 6'h14;
  localparam logic [5:0] OFF_BUF_CTRL  = 6'h18;
  localparam logic [5:0] OFF_ARM       = 6'h1c;

  localparam int SLOPE_BIT          = 3;
  localparam int CTRL_FIFO_CLEAR    = 0;
  localparam int CTRL_TRIG_CLEAR    = 1;
  localparam int ARM_BIT            = 0;

  localparam logic [15:0] DIVISOR_RESET = 16'h0002;
  localparam logic [15:0] DIVISOR_MIN   = 16'h0002;
  localparam logic [7:0]  LEVEL_RESET   = 8'h80;

  localparam logic [2:0] MODE_SOFT   = 3'h0;
  localparam logic [2:0] MODE_POST   = 3'h1;
  localparam logic [2:0] MODE_PRE    = 3'h2;
  localparam logic [2:0] MODE_DELAY  = 3'h3;
  localparam logic [2:0] MODE_MIDDLE = 3'h4;

  localparam int CLK_PERIOD_PS  = 20000;
  localparam int START_DELAY_PS = 350000;
  // A least time, so it rounds up.
  localparam int START_DELAY_CYC = (START_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  typedef struct packed {
    logic       capture_active;
    logic       trigger_seen;
    logic       post_count_zero;
    logic       fifo_output_ready;
    logic       fifo_half_full;
    logic       fifo_input_ready;
  } atcfc_status_t;

  typedef struct packed {
    logic [7:0] ch3;
    logic [7:0] ch2;
    logic [7:0] ch1;
    logic [7:0] ch0;
  } atcfc_samples_t;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_WAIT  = 5'b00010,
    ST_START = 5'b00100,
    ST_RUN   = 5'b01000,
    ST_DONE  = 5'b10000
  } atcfc_state_t;

endpackage : atcfc_pkg

//--- atcfc_ctrl.sv
/*
  Acquisition control: divisor-based sample clock enable, trigger detection,
  post-trigger down counter, sample FIFO with status flags, and a 32-bit
  register port as seen by the PCI target logic (one word per access).
  Assumes the PCI target decodes the base address and hands over word accesses
  on clk; analog samples arrive on clk; the trigger pin is asynchronous.
  The sample clock source is taken as clk itself.
*/
// Operation
// R01 - Sample rate is source over divisor.
// R02 - Sixteen-bit divisor, bit zero reads zero.
// R03 - Three-bit field picks five trigger modes.
// R04 - Illegal mode code blocks all acquisition.
// R05 - Level is offset binary, 0x80 zero.
// R06 - Trigger combines level and separate slope.
// R07 - Slope zero positive, one negative.
// R08 - Source codes pick channel or digital.
// R09 - Digital trigger uses edges, ignores level.
// R10 - Writing count word preloads down counter.
// R11 - Count down per sample, halt at zero.
// R12 - Counter times delay or middle samples.
// R13 - Offset 18h reads status, writes control.
// R14 - Status bit 0 means buffer not full.
// R15 - Status bit 1 means half full.
// R16 - Status bit 2 means buffer not empty.
// R17 - Status bit 3 means counter zero.
// R18 - Status bit 4 trigger seen, sticky.
// R19 - Status bit 5 set while acquiring.
// R20 - Control bit 0 empties the buffer.
// R21 - Control bit 1 clears trigger seen.
// R22 - Arm bit starts, clearing it stops.
// R23 - Post and middle start 350 ns late.
// R24 - Analog trigger fires on level crossing.
// R25 - Pre stores until trigger; delay after count.
// R26 - Unused bits ignored; write-only reads zero.
`timescale 1ns/1ps
`default_nettype none
module atcfc_ctrl #(
  parameter int DEPTH_LOG2 = 10
) (
  input  wire logic                      clk,
  input  wire logic                      rstn,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  input  wire logic [5:0]                reg_addr,
  input  wire logic [31:0]               reg_wdata,
  output logic      [31:0]               reg_rdata,
  input  wire atcfc_pkg::atcfc_samples_t sample_in,
  input  wire logic                      external_digital_trigger,
  input  wire logic                      soft_trigger,
  input  wire logic                      fifo_rd,
  output logic                           fifo_rd_valid,
  output atcfc_pkg::atcfc_samples_t      fifo_rdata,
  output logic                           sample_clk_en
);

  // A buffer under four words has no useful half-full point, so such depths are refused.
  if (DEPTH_LOG2 < 2 || DEPTH_LOG2 > 16) begin : g_depth_check
    $error("DEPTH_LOG2 out of range");
  end

  localparam int DEPTH = 1 << DEPTH_LOG2;
  localparam logic [DEPTH_LOG2:0] HALF = (DEPTH_LOG2 + 1)'(DEPTH / 2);
  localparam logic [DEPTH_LOG2:0] FULL = (DEPTH_LOG2 + 1)'(DEPTH);

  logic [15:0]                    divisor_reg;
  logic [2:0]                     mode_reg;
  logic [7:0]                     level_reg;
  logic [3:0]                     src_reg;
  logic [15:0]                    count_reg;
  logic                           arm_reg;
  logic                           seen_reg;
  logic [15:0]                    div_cnt_reg;
  logic [4:0]                     dly_reg;
  logic [4:0]                     start_len_reg;
  logic                           ext_s1_reg;
  logic                           ext_s2_reg;
  logic                           ext_prev_reg;
  logic                           above_prev_reg;
  logic                           above_valid_reg;
  atcfc_pkg::atcfc_state_t        state_reg;
  atcfc_pkg::atcfc_state_t        state_next;
  atcfc_pkg::atcfc_samples_t      mem [DEPTH];
  logic [DEPTH_LOG2-1:0]          wptr_reg;
  logic [DEPTH_LOG2-1:0]          rptr_reg;
  logic [DEPTH_LOG2:0]            fill_reg;

  wire wr_div   = reg_wr && reg_addr == atcfc_pkg::OFF_DIVISOR;
  wire wr_mode  = reg_wr && reg_addr == atcfc_pkg::OFF_TRIG_MODE;
  wire wr_lvl   = reg_wr && reg_addr == atcfc_pkg::OFF_TRIG_LVL;
  wire wr_src   = reg_wr && reg_addr == atcfc_pkg::OFF_TRIG_SRC;
  wire wr_cnt   = reg_wr && reg_addr == atcfc_pkg::OFF_POST_CNT;
  wire wr_ctrl  = reg_wr && reg_addr == atcfc_pkg::OFF_BUF_CTRL;
  wire wr_arm   = reg_wr && reg_addr == atcfc_pkg::OFF_ARM;
  wire clr_fifo = wr_ctrl && reg_wdata[atcfc_pkg::CTRL_FIFO_CLEAR];
  wire clr_trig = wr_ctrl && reg_wdata[atcfc_pkg::CTRL_TRIG_CLEAR];

  // R03 legal mode decode
  wire mode_legal = mode_reg <= atcfc_pkg::MODE_MIDDLE;
  wire is_pre     = mode_reg == atcfc_pkg::MODE_PRE;
  wire is_delay   = mode_reg == atcfc_pkg::MODE_DELAY;
  wire is_middle  = mode_reg == atcfc_pkg::MODE_MIDDLE;
  wire is_soft    = mode_reg == atcfc_pkg::MODE_SOFT;

  // R01 divided sample enable
  wire [15:0] div_eff = (divisor_reg < atcfc_pkg::DIVISOR_MIN) ? atcfc_pkg::DIVISOR_MIN : divisor_reg;
  assign sample_clk_en = div_cnt_reg == 16'h0000;

  // R08 source select
  logic [7:0] chan_sel;
  assign chan_sel = src_reg[1:0] == 2'h0 ? sample_in.ch0 :
                    src_reg[1:0] == 2'h1 ? sample_in.ch1 :
                    src_reg[1:0] == 2'h2 ? sample_in.ch2 : sample_in.ch3;
  wire use_digital = src_reg[2];
  wire slope_neg   = src_reg[atcfc_pkg::SLOPE_BIT];

  // R05 offset-binary level, plain unsigned compare keeps the order
  wire above_now = chan_sel > level_reg;

  // R24 crossing detect, R06 R07 slope applied
  wire analog_hit = above_valid_reg && sample_clk_en &&
                    (slope_neg ? (above_prev_reg && !above_now) : (!above_prev_reg && above_now));
  // R09 edges only, level unused
  wire digital_hit = slope_neg ? (ext_prev_reg && !ext_s2_reg) : (!ext_prev_reg && ext_s2_reg);
  wire trig_hit = is_soft ? soft_trigger : (use_digital ? digital_hit : analog_hit);

  wire in_wait  = state_reg == atcfc_pkg::ST_WAIT;
  wire in_start = state_reg == atcfc_pkg::ST_START;
  wire in_run   = state_reg == atcfc_pkg::ST_RUN;
  wire trig_ev  = in_wait && trig_hit;

  wire fifo_full  = fill_reg == FULL;
  wire fifo_empty = fill_reg == '0;

  // R25 storing window per mode
  wire storing = in_run ? (!is_delay || count_reg == 16'h0000) && (!is_middle || count_reg != 16'h0000)
                        : (in_wait && is_pre);
  wire push = storing && sample_clk_en && !fifo_full && !clr_fifo;
  wire pop  = fifo_rd && !fifo_empty && !clr_fifo;
  assign fifo_rd_valid = !fifo_empty;

  // R11 count while running after trigger
  wire count_tick = in_run && sample_clk_en && count_reg != 16'h0000 && (is_delay || is_middle);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      atcfc_pkg::ST_IDLE: begin
        // R04 illegal mode never arms
        if (arm_reg && mode_legal) begin
          state_next = atcfc_pkg::ST_WAIT;
        end
      end
      atcfc_pkg::ST_WAIT: begin
        if (trig_ev) begin
          state_next = is_pre ? atcfc_pkg::ST_DONE : atcfc_pkg::ST_START;
        end
      end
      atcfc_pkg::ST_START: begin
        if (dly_reg == 5'h00) begin
          state_next = atcfc_pkg::ST_RUN;
        end
      end
      atcfc_pkg::ST_RUN: begin
        // R12 middle stops after counted samples
        if (is_middle && count_reg == 16'h0000) begin
          state_next = atcfc_pkg::ST_DONE;
        end
      end
      atcfc_pkg::ST_DONE: state_next = atcfc_pkg::ST_DONE;
      default: state_next = atcfc_pkg::ST_IDLE;
    endcase
    // R22 disarm stops
    if (!arm_reg || !mode_legal) begin
      state_next = atcfc_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      divisor_reg <= atcfc_pkg::DIVISOR_RESET;
      mode_reg    <= atcfc_pkg::MODE_SOFT;
      level_reg   <= atcfc_pkg::LEVEL_RESET;
      src_reg     <= 4'h0;
      arm_reg     <= 1'b0;
    end else begin
      // R02 low bit forced to zero, R26 upper bits dropped
      if (wr_div) begin
        divisor_reg <= {reg_wdata[15:1], 1'b0};
      end
      if (wr_mode) begin
        mode_reg <= reg_wdata[2:0];
      end
      if (wr_lvl) begin
        level_reg <= reg_wdata[7:0];
      end
      if (wr_src) begin
        src_reg <= reg_wdata[3:0];
      end
      // R22 arm bit
      if (wr_arm) begin
        arm_reg <= reg_wdata[atcfc_pkg::ARM_BIT];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      div_cnt_reg <= 16'h0000;
    end else if (div_cnt_reg == 16'h0000) begin
      div_cnt_reg <= div_eff - 16'h0001;
    end else begin
      div_cnt_reg <= div_cnt_reg - 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ext_s1_reg   <= 1'b0;
      ext_s2_reg   <= 1'b0;
      ext_prev_reg <= 1'b0;
    end else begin
      ext_s1_reg   <= external_digital_trigger;
      ext_s2_reg   <= ext_s1_reg;
      ext_prev_reg <= ext_s2_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn || !in_wait) begin
      above_prev_reg  <= 1'b0;
      above_valid_reg <= 1'b0;
    end else if (sample_clk_en) begin
      above_prev_reg  <= above_now;
      above_valid_reg <= 1'b1;
    end
  end

  // R10 preload on write, R11 halt at zero
  always_ff @(posedge clk) begin
    if (!rstn) begin
      count_reg <= 16'h0000;
    end else if (wr_cnt) begin
      count_reg <= reg_wdata[15:0];
    end else if (count_tick) begin
      count_reg <= count_reg - 16'h0001;
    end
  end

  // R23 start delay for post and middle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      dly_reg <= 5'h00;
    end else if (trig_ev) begin
      dly_reg <= (mode_reg == atcfc_pkg::MODE_POST || is_middle) ? 5'(atcfc_pkg::START_DELAY_CYC - 1) : 5'h00;
    end else if (in_start && dly_reg != 5'h00) begin
      dly_reg <= dly_reg - 5'h01;
    end
  end

  // R23 start length count
  always_ff @(posedge clk) begin
    if (!rstn || !in_start) begin
      start_len_reg <= 5'h00;
    end else begin
      start_len_reg <= start_len_reg + 5'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_reg <= atcfc_pkg::ST_IDLE;
      // R18 sticky, set wins over R21 clear
      seen_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (trig_ev) begin
        seen_reg <= 1'b1;
      end else if (clr_trig) begin
        seen_reg <= 1'b0;
      end
    end
  end

  // R20 clear empties buffer
  always_ff @(posedge clk) begin
    if (!rstn || clr_fifo) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      fill_reg <= '0;
    end else begin
      if (push) begin
        wptr_reg <= wptr_reg + 1'b1;
      end
      if (pop) begin
        rptr_reg <= rptr_reg + 1'b1;
      end
      fill_reg <= fill_reg + (DEPTH_LOG2 + 1)'(push) - (DEPTH_LOG2 + 1)'(pop);
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr_reg] <= sample_in;
    end
  end
  assign fifo_rdata = mem[rptr_reg];

  atcfc_pkg::atcfc_status_t status;
  // R14 R15 R16 R17 R19 status flags
  assign status.fifo_input_ready  = !fifo_full;
  assign status.fifo_half_full    = fill_reg >= HALF;
  assign status.fifo_output_ready = !fifo_empty;
  assign status.post_count_zero   = count_reg == 16'h0000;
  assign status.trigger_seen      = seen_reg;
  assign status.capture_active    = storing;

  // R13 shared offset, R26 write-only reads zero
  always_ff @(posedge clk) begin
    if (!rstn) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= (reg_addr == atcfc_pkg::OFF_BUF_CTRL) ? {26'h0, status} : 32'h0000_0000;
    end
  end

  // R02 low divisor bit
  a_div_lsb_zero: assert property (@(posedge clk) disable iff (!rstn) divisor_reg[0] == 1'b0) // R02
    else $error("divisor low bit set");
  a_illegal_idle: assert property (@(posedge clk) disable iff (!rstn) !mode_legal |=> state_reg == atcfc_pkg::ST_IDLE) // R04
    else $error("acquiring under illegal mode");
  a_count_preload: assert property (@(posedge clk) disable iff (!rstn) wr_cnt |=> count_reg == $past(reg_wdata[15:0])) // R10
    else $error("counter not preloaded");
  a_count_holds_zero: assert property (@(posedge clk) disable iff (!rstn) // R11
      (count_reg == 16'h0000 && !wr_cnt) |=> count_reg == 16'h0000)
    else $error("counter left zero");
  a_seen_sticky: assert property (@(posedge clk) disable iff (!rstn) (seen_reg && !clr_trig) |=> seen_reg) // R18
    else $error("trigger flag dropped");
  a_seen_clear: assert property (@(posedge clk) disable iff (!rstn) (clr_trig && !trig_ev) |=> !seen_reg) // R21
    else $error("trigger flag not cleared");
  a_fifo_cleared: assert property (@(posedge clk) disable iff (!rstn) clr_fifo |=> fifo_empty) // R20
    else $error("buffer not emptied");
  a_post_delay: assert property (@(posedge clk) disable iff (!rstn) // R23
      (trig_ev && mode_reg == atcfc_pkg::MODE_POST && arm_reg) |=> in_start [*8])
    else $error("start delay too short");
  a_disarm_stops: assert property (@(posedge clk) disable iff (!rstn) !arm_reg |=> !status.capture_active) // R22
    else $error("acquiring while disarmed");
  a_status_read: assert property (@(posedge clk) disable iff (!rstn) // R13
      (reg_rd && reg_addr == atcfc_pkg::OFF_BUF_CTRL) |=> reg_rdata[5:0] == $past(status))
    else $error("status read mismatch");
  a_sample_period: assert property (@(posedge clk) disable iff (!rstn) sample_clk_en |=> !sample_clk_en) // R01
    else $error("sample enable too fast");
  a_count_step: assert property (@(posedge clk) disable iff (!rstn) // R11
      (count_tick && !wr_cnt) |=> count_reg == $past(count_reg) - 16'h0001)
    else $error("counter did not step");
  a_fill_bound: assert property (@(posedge clk) disable iff (!rstn) fill_reg <= FULL) // R14
    else $error("buffer fill overran");
  a_empty_stays: assert property (@(posedge clk) disable iff (!rstn) (fifo_empty && !push) |=> fifo_empty) // R16
    else $error("empty buffer produced data");
  a_seen_on_trigger: assert property (@(posedge clk) disable iff (!rstn) trig_ev |=> seen_reg) // R18
    else $error("trigger flag not set");
  a_delay_no_store: assert property (@(posedge clk) disable iff (!rstn) // R25
      (is_delay && count_reg != 16'h0000) |-> !push)
    else $error("delay mode stored early");
  a_middle_done: assert property (@(posedge clk) disable iff (!rstn) // R12
      (in_run && is_middle && count_reg == 16'h0000) |=> !in_run)
    else $error("middle mode kept running");
  a_pre_stops: assert property (@(posedge clk) disable iff (!rstn) (trig_ev && is_pre) |=> !status.capture_active) // R25
    else $error("pre mode kept storing");
  a_start_length: assert property (@(posedge clk) disable iff (!rstn) // R23
      (in_start && state_next == atcfc_pkg::ST_RUN && (mode_reg == atcfc_pkg::MODE_POST || is_middle))
      |-> start_len_reg == 5'(atcfc_pkg::START_DELAY_CYC - 1))
    else $error("start delay length wrong");
  a_arm_waits: assert property (@(posedge clk) disable iff (!rstn) // R22
      (state_reg == atcfc_pkg::ST_IDLE && arm_reg && mode_legal) |=> in_wait)
    else $error("arming did not wait for trigger");
  a_rdata_zero: assert property (@(posedge clk) disable iff (!rstn) // R26
      (reg_rd && reg_addr != atcfc_pkg::OFF_BUF_CTRL) |=> reg_rdata == 32'h0000_0000)
    else $error("write-only read not zero");

endmodule : atcfc_ctrl
`default_nettype wire

//--- atcfc_host.sv
/*
  Host driver model for the register port of the acquisition control block.
  Assumes every call starts just after a rising edge of clk, and ends the same way.
*/
`timescale 1ns/1ps
`default_nettype none
module atcfc_host (
  input  wire logic        clk,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic [5:0]       reg_addr,
  output logic [31:0]      reg_wdata,
  input  wire logic [31:0] reg_rdata
);
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 6'h3f;
    reg_wdata = 32'h0;
  end
  task wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] w;
    w = d;
    if (a == atcfc_pkg::OFF_DIVISOR && d[15:0] < atcfc_pkg::DIVISOR_MIN) w[15:0] = atcfc_pkg::DIVISOR_MIN;
    reg_addr  = a;
    reg_wdata = w;
    reg_wr    = 1'b1;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    // Released lines must not keep showing the old value.
    reg_addr  = ~a;
    reg_wdata = ~w;
    // An idle edge keeps back-to-back calls from toggling a strobe twice in one time step.
    @(posedge clk);
    #1;
  endtask : wr
  task rd(input logic [5:0] a, output logic [31:0] d);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge clk);
    #1;
    reg_rd   = 1'b0;
    reg_addr = ~a;
    d        = reg_rdata;
    @(posedge clk);
    #1;
  endtask : rd
  task arm(input logic on);
    wr(atcfc_pkg::OFF_ARM, {31'h0, on});
  endtask : arm
  task ctl(input logic [1:0] bits);
    wr(atcfc_pkg::OFF_BUF_CTRL, {30'h0, bits});
  endtask : ctl
endmodule : atcfc_host
`default_nettype wire

//--- atcfc_ctrl_tb.sv
/*
  Self-checking bench for the acquisition control block, with a small buffer.
  Assumes the host model drives the register port; samples and trigger pin come from here.
*/
`timescale 1ns/1ps
`default_nettype none
module atcfc_ctrl_tb;
  localparam int DL2   = 4;
  localparam int DEPTH = 1 << DL2;
  logic                      clk, rstn, reg_wr, reg_rd, ext_trig, soft_trigger, fifo_rd, fifo_rd_valid, sample_clk_en;
  logic [5:0]                reg_addr;
  logic [7:0]                b;
  logic [31:0]               reg_wdata, reg_rdata, st, lf, v;
  atcfc_pkg::atcfc_samples_t fifo_rdata, smp;
  int                        err_count, tests_run, cyc, n, d, k, s, sl;

  atcfc_ctrl #(.DEPTH_LOG2(DL2)) dut (.clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .sample_in(smp), .external_digital_trigger(ext_trig),
    .soft_trigger(soft_trigger), .fifo_rd(fifo_rd), .fifo_rd_valid(fifo_rd_valid),
    .fifo_rdata(fifo_rdata), .sample_clk_en(sample_clk_en));
  atcfc_host host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  initial clk = 1'b0;
  always #10 clk = ~clk;

  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr_next
  task step(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : step
  task chk_word(input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk_word
  task chk_num(input int e, input int g);
    tests_run++;
    if (g != e) begin
      err_count++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk_num
  task chk_st(input logic [31:0] m, input logic [31:0] e);
    host.rd(atcfc_pkg::OFF_BUF_CTRL, st);
    chk_word(e, st & m);
  endtask : chk_st
  task pop();
    fifo_rd = 1'b1;
    step(1);
    fifo_rd = 1'b0;
    step(1);
  endtask : pop
  // The first pulse after a divisor write may be short, so the second interval is the one measured.
  task period(output int p);
    p = 0;
    while (sample_clk_en !== 1'b1 && p < 40) begin
      step(1);
      p++;
    end
    p = 0;
    do begin
      step(1);
      p++;
    end while (sample_clk_en !== 1'b1 && p < 40);
  endtask : period
  task complete_run();
    $display("tests_run=%0d err_count=%0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      complete_run();
    end
  end

  initial begin
    rstn = 1'b0; ext_trig = 1'b0; soft_trigger = 1'b0; fifo_rd = 1'b0; smp = 32'h0;
    lf = 32'h00011854; err_count = 0; tests_run = 0; cyc = 0;
    repeat (2) @(posedge clk);
    #1 rstn = 1'b1;
    step(1);
    chk_st(32'hffffffff, 32'h09);
    host.rd(atcfc_pkg::OFF_DIVISOR, st);
    chk_word(32'h0, st);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      lf = lfsr_next(lf);
      d = (i == 0) ? 3 : 2 * (lf[2:0] + 1);
      host.wr(atcfc_pkg::OFF_DIVISOR, {lf[31:16], d[15:0]});
      period(n);
      chk_num((i == 0) ? 2 : d, n);
    end
    host.wr(atcfc_pkg::OFF_DIVISOR, 32'h2);
    $display("test divisor done");
    lf = lfsr_next(lf); smp = lf; v = lf;
    host.wr(atcfc_pkg::OFF_TRIG_MODE, {lf[31:3], atcfc_pkg::MODE_SOFT});
    host.arm(1'b1);
    step(4);
    chk_st(32'h3f, 32'h09);
    soft_trigger = 1'b1; step(1); soft_trigger = 1'b0;
    step(4 * DEPTH);
    chk_st(32'h3f, 32'h3e);
    host.wr(atcfc_pkg::OFF_BUF_CTRL, 32'h0);
    chk_st(32'h10, 32'h10);
    host.arm(1'b0);
    host.ctl(2'h2);
    chk_st(32'h3f, 32'h0e);
    for (int i = 0; i < DEPTH / 2 + 2; i++) begin
      if (i >= DEPTH / 2) chk_st(32'h02, (i == DEPTH / 2) ? 32'h02 : 32'h0);
      chk_word(v, fifo_rdata);
      pop();
    end
    host.ctl(2'h1);
    chk_st(32'h07, 32'h01);
    chk_word(32'h0, {31'h0, fifo_rd_valid});
    $display("test buffer done");
    for (int m = 5; m < 8; m++) begin
      host.wr(atcfc_pkg::OFF_TRIG_MODE, 32'(m));
      host.arm(1'b1);
      soft_trigger = 1'b1; step(1); soft_trigger = 1'b0;
      step(20);
      chk_st(32'h24, 32'h0);
      host.arm(1'b0);
    end
    $display("test illegal done");
    host.wr(atcfc_pkg::OFF_TRIG_MODE, {29'h0, atcfc_pkg::MODE_POST});
    for (int c = 0; c < 10; c++) begin
      s = c / 2; sl = c % 2; lf = lfsr_next(lf);
      host.ctl(2'h3);
      host.wr(atcfc_pkg::OFF_TRIG_SRC, {lf[31:4], sl[0], (s == 4) ? {1'b1, lf[1:0]} : s[2:0]});
      host.wr(atcfc_pkg::OFF_TRIG_LVL, {lf[23:0], 8'h40 + {1'b0, lf[30:24]}});
      b = sl[0] ? 8'hf0 : 8'h10;
      smp = {4{b}}; ext_trig = sl[0];
      host.arm(1'b1);
      step(10);
      if (s == 4) smp = {4{~b}};
      else begin
        smp[8 * ((s + 1) % 4) +: 8] = ~b;
        ext_trig = ~sl[0];
      end
      step(8);
      chk_st(32'h10, 32'h0);
      if (s == 4) ext_trig = ~sl[0];
      else smp[8 * s +: 8] = ~b;
      step(8);
      chk_st(32'h14, 32'h10);
      step(30);
      chk_st(32'h34, 32'h34);
      host.arm(1'b0);
    end
    $display("test sources done");
    for (int m = 2; m < 5; m++) begin
      lf = lfsr_next(lf); k = 5 + lf[2:0];
      host.ctl(2'h3);
      host.wr(atcfc_pkg::OFF_TRIG_SRC, 32'h4);
      ext_trig = 1'b0;
      host.wr(atcfc_pkg::OFF_POST_CNT, {lf[31:16], k[15:0]});
      host.wr(atcfc_pkg::OFF_TRIG_MODE, 32'(m));
      chk_st(32'h08, 32'h0);
      host.arm(1'b1);
      step(4 * DEPTH);
      chk_st(32'h24, (m == 2) ? 32'h24 : 32'h0);
      ext_trig = 1'b1;
      step(6);
      chk_st(32'h3c, (m == 2) ? 32'h14 : 32'h10);
      step(2 * k + 40);
      chk_st(32'h3c, (m == 2) ? 32'h14 : (m == 3) ? 32'h3c : 32'h1c);
      if (m == 4) begin
        n = 0;
        while (fifo_rd_valid === 1'b1 && n < 20) begin
          pop();
          n++;
        end
        chk_num(k, n);
      end
      host.arm(1'b0);
    end
    $display("test counter done");
    complete_run();
  end
endmodule : atcfc_ctrl_tb
`default_nettype wire
